//--- hdl/ctu_top.sv
// Charge time unit control logic with APB register slave
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/100ps
module ctu_top
(
    input  wire logic        pclk,           // System clock, 100 MHz
    input  wire logic        presetn,        // Async reset, active low
    input  wire logic        psel,           // APB select
    input  wire logic        penable,        // APB enable
    input  wire logic        pwrite,         // APB write
    input  wire logic [7:0]  paddr,          // APB byte address
    input  wire logic [31:0] pwdata,         // APB write data
    output logic      [31:0] prdata,         // APB read data
    output logic             pready,         // APB ready
    output logic             pslverr,        // APB error, unmapped address
    input  wire logic        edge_pin_1,     // External edge input 1
    input  wire logic        edge_pin_2,     // External edge input 2
    input  wire logic        timer_evt,      // Timer edge source
    input  wire logic        compare_evt,    // Output compare edge source
    output logic             src_en,         // Current source enable
    output logic             discharge_ctl,  // Drains connected circuit
    output logic             delay_mode,     // 1 pulse delay, 0 measure
    output logic             unit_on,        // Analog unit powered
    output logic      [1:0]  range_sel,      // Current range to analog
    output logic      [5:0]  trim_val,       // Current trim to analog
    output logic             irq             // Interrupt request
);

    //--------------------------------------------------------------------
    // State
    //--------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  cur_ctl;
        logic        pol1;
        logic        pol2;
        logic [1:0]  sel1;
        logic [1:0]  sel2;
        logic        s1;
        logic        s2;
        logic        unit_en;
        logic        mode;
        logic        edges_en;
        logic        seq_en;
        logic        dis_en;
        logic        flag;
        logic        ien;
        logic        src_en;
        logic        irq;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } ctu_state_t;

    ctu_state_t st;
    ctu_state_t next_st;

    //--------------------------------------------------------------------
    // Functions
    //--------------------------------------------------------------------
    function automatic logic [2:0] reg_index(input logic [7:0] a);
        logic [2:0] idx;
        idx = ctu_pkg::IDX_NONE;
        case (a)
            ctu_pkg::ADDR_CUR:  idx = ctu_pkg::IDX_CUR;
            ctu_pkg::ADDR_LOW:  idx = ctu_pkg::IDX_LOW;
            ctu_pkg::ADDR_HIGH: idx = ctu_pkg::IDX_HIGH;
            ctu_pkg::ADDR_FLAG: idx = ctu_pkg::IDX_FLAG;
            ctu_pkg::ADDR_IEN:  idx = ctu_pkg::IDX_IEN;
            default:            idx = ctu_pkg::IDX_NONE;
        endcase
        return idx;
    endfunction

    // Level of the selected source after polarity; pol 0 is active low
    function automatic logic chan_active(
        input logic [1:0] sel,
        input logic       pol,
        input logic       p1,
        input logic       p2,
        input logic       tmr,
        input logic       cmp
    );
        logic lvl;
        lvl = 1'b0;
        case (sel)
            ctu_pkg::SRC_PIN1:    lvl = p1;
            ctu_pkg::SRC_PIN2:    lvl = p2;
            ctu_pkg::SRC_TIMER:   lvl = tmr;
            ctu_pkg::SRC_COMPARE: lvl = cmp;
            default:              lvl = p1;
        endcase
        return (lvl == pol);
    endfunction

    //--------------------------------------------------------------------
    // Decode and channel levels
    //--------------------------------------------------------------------
    logic [2:0] idx;
    logic       setup_ph;
    logic       wr_fire;
    logic       act1;
    logic       act2;
    logic       gate;
    logic [7:0] rd_byte;

    assign idx      = reg_index(paddr);
    assign setup_ph = psel && !penable;
    assign wr_fire  = psel && penable && st.pready && pwrite;
    // Level sensitive, so a config change matching the input fires too
    assign act1 = chan_active(st.sel1, st.pol1, edge_pin_1, edge_pin_2,
                              timer_evt, compare_evt);
    assign act2 = chan_active(st.sel2, st.pol2, edge_pin_1, edge_pin_2,
                              timer_evt, compare_evt);
    assign gate = st.unit_en && st.edges_en;

    always_comb
    begin
        rd_byte = 8'h00;
        case (idx)
            ctu_pkg::IDX_CUR:  rd_byte = st.cur_ctl;
            ctu_pkg::IDX_LOW:  rd_byte = {st.pol2, st.sel2, st.pol1,
                                          st.sel1, st.s2, st.s1};
            ctu_pkg::IDX_HIGH:
            begin
                rd_byte[ctu_pkg::HIGH_UNIT]  = st.unit_en;
                rd_byte[ctu_pkg::HIGH_DELAY] = st.mode;
                rd_byte[ctu_pkg::HIGH_EDGES] = st.edges_en;
                rd_byte[ctu_pkg::HIGH_SEQ]   = st.seq_en;
                rd_byte[ctu_pkg::HIGH_DIS]   = st.dis_en;
            end
            ctu_pkg::IDX_FLAG: rd_byte[ctu_pkg::FLAG_BIT] = st.flag;
            ctu_pkg::IDX_IEN:  rd_byte[ctu_pkg::FLAG_BIT] = st.ien;
            default:           rd_byte = 8'h00;
        endcase
    end

    //--------------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        // APB: answer prepared in setup, completes in first access cycle
        if (setup_ph)
        begin
            next_st.pready  = 1'b1;
            next_st.pslverr = (idx == ctu_pkg::IDX_NONE);
            next_st.prdata  = {24'h00_0000, rd_byte};
        end
        // Ready falls after one cycle even if the master lets go early,
        // so an aborted transfer cannot leave the bus stuck
        else if (st.pready)
        begin
            next_st.pready  = 1'b0;
            next_st.pslverr = 1'b0;
            next_st.prdata  = ctu_pkg::RST_DATA;
        end
        // Register writes; hardware sets below override status clears
        if (wr_fire)
        begin
            case (idx)
                ctu_pkg::IDX_CUR:  next_st.cur_ctl = pwdata[7:0];
                ctu_pkg::IDX_LOW:
                begin
                    next_st.s1   = pwdata[ctu_pkg::LOW_S1];
                    next_st.s2   = pwdata[ctu_pkg::LOW_S2];
                    next_st.sel1 = pwdata[ctu_pkg::LOW_SEL1_LO +: 2];
                    next_st.pol1 = pwdata[ctu_pkg::LOW_POL1];
                    next_st.sel2 = pwdata[ctu_pkg::LOW_SEL2_LO +: 2];
                    next_st.pol2 = pwdata[ctu_pkg::LOW_POL2];
                end
                ctu_pkg::IDX_HIGH:
                begin
                    next_st.unit_en  = pwdata[ctu_pkg::HIGH_UNIT];
                    next_st.mode     = pwdata[ctu_pkg::HIGH_DELAY];
                    next_st.edges_en = pwdata[ctu_pkg::HIGH_EDGES];
                    next_st.seq_en   = pwdata[ctu_pkg::HIGH_SEQ];
                    next_st.dis_en   = pwdata[ctu_pkg::HIGH_DIS];
                end
                ctu_pkg::IDX_FLAG: next_st.flag = pwdata[ctu_pkg::FLAG_BIT];
                ctu_pkg::IDX_IEN:  next_st.ien  = pwdata[ctu_pkg::FLAG_BIT];
                default:           next_st.flag = next_st.flag;
            endcase
        end
        // Edge detection
        if (gate && act1)
        begin
            next_st.s1 = 1'b1;
        end
        // Sequenced channel 2 waits for the edge 1 status
        if (gate && act2 && (!st.seq_en || st.s1))
        begin
            next_st.s2 = 1'b1;
        end
        next_st.src_en = next_st.unit_en
                         && (next_st.s1 ^ next_st.s2);
        // Set beats a same-cycle software clear of the flag
        if (st.src_en && !next_st.src_en)
        begin
            next_st.flag = 1'b1;
        end
        next_st.irq = next_st.flag && next_st.ien;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // Constants only: reset must not depend on live state
            st          <= '0;
            st.cur_ctl  <= ctu_pkg::RST_CUR;
            st.pol1     <= ctu_pkg::RST_POL;
            st.pol2     <= ctu_pkg::RST_POL;
            st.sel1     <= ctu_pkg::RST_SEL;
            st.sel2     <= ctu_pkg::RST_SEL;
            st.prdata   <= ctu_pkg::RST_DATA;
        end
        else
        begin
            st <= next_st;
        end
    end

    //--------------------------------------------------------------------
    // Outputs
    //--------------------------------------------------------------------
    assign prdata        = st.prdata;
    assign pready        = st.pready;
    assign pslverr       = st.pslverr;
    assign src_en        = st.src_en;
    assign discharge_ctl = st.dis_en;
    assign delay_mode    = st.mode;
    assign unit_on       = st.unit_en;
    // Trim is two's complement, about two percent per step
    assign range_sel     = st.cur_ctl[ctu_pkg::CUR_RANGE_LO +: 2];
    assign trim_val      = st.cur_ctl[ctu_pkg::CUR_TRIM_LO +: 6];
    assign irq           = st.irq;

    //--------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence apb_setup_s;
        psel && !penable;
    endsequence

    sequence src_fall_s;
        src_en ##1 !src_en;
    endsequence

    src_exact_one_a: assert property (
        src_en == (unit_on && (st.s1 ^ st.s2)))
        else $error("source enable not tied to one status bit");

    edge1_sets_a: assert property (
        gate && act1 |=> st.s1)
        else $error("edge 1 response did not set status");

    status_write_a: assert property (
        wr_fire && idx == ctu_pkg::IDX_LOW && !gate && unit_on
        && (pwdata[0] ^ pwdata[1]) |=> src_en)
        else $error("status write did not enable source");

    flag_on_fall_a: assert property (
        src_fall_s |-> st.flag)
        else $error("flag not set when source turned off");

    irq_gating_a: assert property (
        irq == (st.flag && st.ien))
        else $error("interrupt without flag and enable");

    seq_block_a: assert property (
        st.seq_en && !st.s1 && !st.s2 && !wr_fire |=> !st.s2)
        else $error("edge 2 accepted before edge 1");

    edges_off_a: assert property (
        !st.edges_en && !st.s1 && !wr_fire |=> !st.s1)
        else $error("blocked edge set status");

    discharge_wr_a: assert property (
        wr_fire && idx == ctu_pkg::IDX_HIGH
        |=> discharge_ctl == $past(pwdata[ctu_pkg::HIGH_DIS]))
        else $error("discharge control not following write");

    range_wr_a: assert property (
        wr_fire && idx == ctu_pkg::IDX_CUR
        |=> range_sel == $past(pwdata[1:0])
            && trim_val == $past(pwdata[7:2]))
        else $error("range or trim not following write");

    apb_ready_a: assert property (
        apb_setup_s |=> pready ##1 !pready)
        else $error("ready not one cycle after setup");

    //--------------------------------------------------------------------
    // Bus answer checks
    //--------------------------------------------------------------------
    // Error only rides on the one ready cycle of a transfer
    err_with_ready_a: assert property (
        pslverr |-> pready)
        else $error("error response outside ready cycle");

    // Idle read bus stays zero so a stray sample cannot look valid
    rdata_idle_a: assert property (
        !pready |-> prdata == ctu_pkg::RST_DATA)
        else $error("read data not zero while idle");

    ready_after_setup_a: assert property (
        pready |-> $past(psel && !penable))
        else $error("ready without a setup cycle");

    //--------------------------------------------------------------------
    // Status and source checks
    //--------------------------------------------------------------------
    sequence flag_clear_s;
        wr_fire && idx == ctu_pkg::IDX_FLAG
        && !pwdata[ctu_pkg::FLAG_BIT];
    endsequence

    edge2_sets_a: assert property (
        gate && act2 && (!st.seq_en || st.s1) |=> st.s2)
        else $error("edge 2 response did not set status");

    // A held active level must survive a same-cycle software clear
    set_wins_a: assert property (
        gate && act1 && wr_fire && idx == ctu_pkg::IDX_LOW
        |=> st.s1)
        else $error("held level lost to a status clear");

    status_off_a: assert property (
        wr_fire && idx == ctu_pkg::IDX_LOW && !gate
        && !(pwdata[ctu_pkg::LOW_S1] ^ pwdata[ctu_pkg::LOW_S2])
        |=> !src_en)
        else $error("status write did not disable source");

    unit_off_a: assert property (
        !unit_on |-> !src_en)
        else $error("source on while unit off");

    edge2_off_a: assert property (
        !gate && !st.s2 && !wr_fire |=> !st.s2)
        else $error("blocked edge 2 set status");

    flag_sticky_a: assert property (
        st.flag && !wr_fire |=> st.flag)
        else $error("flag dropped without a write");

    // Clear lands unless the source falls in the same cycle
    flag_clear_a: assert property (
        flag_clear_s ##1 !$fell(src_en) |-> !st.flag)
        else $error("flag clear did not take effect");

    ien_wr_a: assert property (
        wr_fire && idx == ctu_pkg::IDX_IEN
        |=> st.ien == $past(pwdata[ctu_pkg::FLAG_BIT]))
        else $error("interrupt enable not following write");

    //--------------------------------------------------------------------
    // Control checks
    //--------------------------------------------------------------------
    mode_wr_a: assert property (
        wr_fire && idx == ctu_pkg::IDX_HIGH
        |=> delay_mode == $past(pwdata[ctu_pkg::HIGH_DELAY])
            && unit_on == $past(pwdata[ctu_pkg::HIGH_UNIT]))
        else $error("mode or unit enable not following write");

    // First edge out of reset: polarity back to active low
    reset_pol_a: assert property (
        $rose(presetn) |-> !st.pol1 && !st.pol2 && !src_en)
        else $error("polarity not at reset value");

endmodule

//--- hdl/ctu_pkg.sv
// Constants, register map and field layout of the charge time unit
//------------------------------------------------------------------------
//------------------------------------------------------------------------
package ctu_pkg;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    // Register byte addresses
    localparam logic [7:0]  ADDR_CUR      = 8'h00;
    localparam logic [7:0]  ADDR_LOW      = 8'h04;
    localparam logic [7:0]  ADDR_HIGH     = 8'h08;
    localparam logic [7:0]  ADDR_FLAG     = 8'h0C;
    localparam logic [7:0]  ADDR_IEN      = 8'h10;
    // Register index codes from the decoder
    localparam logic [2:0]  IDX_CUR       = 3'h0;
    localparam logic [2:0]  IDX_LOW       = 3'h1;
    localparam logic [2:0]  IDX_HIGH      = 3'h2;
    localparam logic [2:0]  IDX_FLAG      = 3'h3;
    localparam logic [2:0]  IDX_IEN       = 3'h4;
    localparam logic [2:0]  IDX_NONE      = 3'h7;
    // Edge control low fields
    localparam int          LOW_S1        = 0;
    localparam int          LOW_S2        = 1;
    localparam int          LOW_SEL1_LO   = 2;
    localparam int          LOW_POL1      = 4;
    localparam int          LOW_SEL2_LO   = 5;
    localparam int          LOW_POL2      = 7;
    // Unit control high fields
    localparam int          HIGH_DIS      = 1;
    localparam int          HIGH_SEQ      = 2;
    localparam int          HIGH_EDGES    = 3;
    localparam int          HIGH_DELAY    = 4;
    localparam int          HIGH_UNIT     = 7;
    // Current control fields
    localparam int          CUR_RANGE_LO  = 0;
    localparam int          CUR_TRIM_LO   = 2;
    // Flag and enable bit position
    localparam int          FLAG_BIT      = 2;
    // Source select codes
    localparam logic [1:0]  SRC_PIN1      = 2'h0;
    localparam logic [1:0]  SRC_PIN2      = 2'h1;
    localparam logic [1:0]  SRC_TIMER     = 2'h2;
    localparam logic [1:0]  SRC_COMPARE   = 2'h3;
    // Reset values
    localparam logic [7:0]  RST_CUR       = 8'h00;
    localparam logic        RST_POL       = 1'b0;
    localparam logic [1:0]  RST_SEL       = 2'h0;
    localparam logic [31:0] RST_DATA      = 32'h0000_0000;
endpackage

//--- sim/ctu_edge_src.sv
// Edge source model: drives the four level inputs after a set lag
`timescale 1ns/100ps
module ctu_edge_src
(
    input  wire logic       pclk,        // System clock
    input  wire logic       presetn,     // Async reset, active low
    input  wire logic [3:0] lvl_req,     // Wanted {cmp, tmr, pin2, pin1}
    input  wire logic [1:0] lag,         // Response lag select, 0 to 3 gives 1 to 4 cycles
    output logic            edge_pin_1,  // External edge input 1
    output logic            edge_pin_2,  // External edge input 2
    output logic            timer_evt,   // Timer level
    output logic            compare_evt  // Output compare level
);
    logic [3:0] stage [4];

    // Levels are held, not pulsed; a slow source only answers later
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stage <= '{default: 4'h0};
        end
        else
        begin
            stage[0] <= lvl_req;
            stage[1] <= stage[0];
            stage[2] <= stage[1];
            stage[3] <= stage[2];
        end
    end

    assign {compare_evt, timer_evt, edge_pin_2, edge_pin_1} = stage[lag];
endmodule

//--- sim/tb_top.sv
// Self-checking testbench of the charge time unit control logic
`timescale 1ns/100ps
module tb_top;
    typedef struct packed
    {
        logic [7:0] cfg;
        logic [3:0] lvl;
        logic [1:0] lag;
        logic [1:0] st;
    } ctu_row_t;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        edge_pin_1;
    logic        edge_pin_2;
    logic        timer_evt;
    logic        compare_evt;
    logic        src_en;
    logic        discharge_ctl;
    logic        delay_mode;
    logic        unit_on;
    logic [1:0]  range_sel;
    logic [5:0]  trim_val;
    logic        irq;
    logic [3:0]  lvl_req = 4'h0;
    logic [1:0]  lag = 2'h0;
    logic [31:0] rdat;
    logic        rerr;
    int          failures = 0;
    int          checked = 0;
    ctu_row_t    rows [8];
    logic [7:0]  curv [5];

    ctu_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .edge_pin_1(edge_pin_1), .edge_pin_2(edge_pin_2),
        .timer_evt(timer_evt), .compare_evt(compare_evt), .src_en(src_en),
        .discharge_ctl(discharge_ctl), .delay_mode(delay_mode),
        .unit_on(unit_on), .range_sel(range_sel), .trim_val(trim_val),
        .irq(irq));

    ctu_edge_src src_model (.pclk(pclk), .presetn(presetn),
        .lvl_req(lvl_req), .lag(lag), .edge_pin_1(edge_pin_1),
        .edge_pin_2(edge_pin_2), .timer_evt(timer_evt),
        .compare_evt(compare_evt));

    //------------------------------------------------------------------
    // Clock, watchdog and shared tasks
    //------------------------------------------------------------------
    initial
    begin
        forever #5 pclk = ~pclk;
    end

    // Whole run is a few hundred cycles; this leaves ample margin
    initial
    begin
        repeat (20000) @(posedge pclk);
        failures++;
        end_sim();
    end

    task automatic end_sim();
        $display("checks=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            failures++;
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Request held until pready is sampled high; no latency assumed,
    // a transfer that never completes is ended by the watchdog
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h00_0000, d});
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdat, {24'h00_0000, e});
    endtask

    //------------------------------------------------------------------
    // Main sequence
    //------------------------------------------------------------------
    initial
    begin
        rows = '{'{8'hF0, 4'h1, 2'h0, 2'h1}, '{8'hF4, 4'h2, 2'h1, 2'h1},
                 '{8'hF8, 4'h4, 2'h2, 2'h1}, '{8'hFC, 4'h8, 2'h3, 2'h3},
                 '{8'hE0, 4'h0, 2'h0, 2'h1}, '{8'h30, 4'h0, 2'h1, 2'h2},
                 '{8'hF0, 4'h0, 2'h2, 2'h0}, '{8'hD0, 4'h4, 2'h3, 2'h2}};
        curv = '{8'h01, 8'h85, 8'h7D, 8'h02, 8'h03};
        wt(16);
        presetn <= 1'b1;
        wt(2);
        chk({19'h0_0000, src_en, discharge_ctl, delay_mode, unit_on,
             range_sel, trim_val, irq}, 32'h0000_0000);
        for (int i = 0; i < 5; i++)
            rd(8'(4 * i), 8'h00);
        apb(1'b1, 8'h14, 32'hFFFF_FFFF);
        chk({31'h0, rerr}, 32'h0000_0001);
        apb(1'b0, 8'h14, 32'h0000_0000);
        chk({rdat[30:0], rerr}, 32'h0000_0001);
        // Setup order: range and trim, then modes and enables, then sources
        foreach (curv[i])
        begin
            wr(ctu_pkg::ADDR_CUR, curv[i]);
            wt(2);
            chk({24'h00_0000, trim_val, range_sel}, {24'h0, curv[i]});
            rd(ctu_pkg::ADDR_CUR, curv[i]);
        end
        wr(ctu_pkg::ADDR_HIGH, 8'h92);
        wt(2);
        chk({29'h0, delay_mode, discharge_ctl, unit_on}, 32'h0000_0007);
        rd(ctu_pkg::ADDR_HIGH, 8'h92);
        wr(ctu_pkg::ADDR_HIGH, 8'h00);
        wt(2);
        chk({29'h0, delay_mode, discharge_ctl, unit_on}, 32'h0000_0000);
        // Sources, polarities and levels; edges held off while reconfiguring
        foreach (rows[i])
        begin
            wr(ctu_pkg::ADDR_HIGH, 8'h80);
            lvl_req <= rows[i].lvl;
            lag <= rows[i].lag;
            wt(5);
            wr(ctu_pkg::ADDR_LOW, rows[i].cfg);
            wr(ctu_pkg::ADDR_HIGH, 8'h88);
            wt(3);
            rd(ctu_pkg::ADDR_LOW, rows[i].cfg | {6'h00, rows[i].st});
            chk({31'h0, src_en}, {31'h0, ^rows[i].st});
        end
        // Edge gating, unit enable and configuration that matches at once
        wr(ctu_pkg::ADDR_HIGH, 8'h80);
        lvl_req <= 4'h0;
        lag <= 2'h0;
        wt(3);
        wr(ctu_pkg::ADDR_LOW, 8'hE0);
        wt(3);
        rd(ctu_pkg::ADDR_LOW, 8'hE0);
        wr(ctu_pkg::ADDR_HIGH, 8'h88);
        wt(3);
        rd(ctu_pkg::ADDR_LOW, 8'hE1);
        chk({31'h0, src_en}, 32'h0000_0001);
        wr(ctu_pkg::ADDR_HIGH, 8'h08);
        wt(2);
        chk({30'h0, src_en, unit_on}, 32'h0000_0000);
        wr(ctu_pkg::ADDR_HIGH, 8'h80);
        wr(ctu_pkg::ADDR_LOW, 8'hF0);
        wr(ctu_pkg::ADDR_HIGH, 8'h88);
        wt(3);
        rd(ctu_pkg::ADDR_LOW, 8'hF0);
        wr(ctu_pkg::ADDR_LOW, 8'hE0);
        wt(3);
        rd(ctu_pkg::ADDR_LOW, 8'hE1);
        wr(ctu_pkg::ADDR_LOW, 8'hE0);
        wt(2);
        rd(ctu_pkg::ADDR_LOW, 8'hE1);
        // Software-driven source, flag and interrupt masking
        wr(ctu_pkg::ADDR_HIGH, 8'h80);
        wr(ctu_pkg::ADDR_LOW, 8'h00);
        wr(ctu_pkg::ADDR_FLAG, 8'h00);
        wr(ctu_pkg::ADDR_IEN, 8'h04);
        wr(ctu_pkg::ADDR_LOW, 8'h01);
        wt(2);
        chk({30'h0, src_en, irq}, 32'h0000_0002);
        wr(ctu_pkg::ADDR_LOW, 8'h03);
        wt(2);
        chk({30'h0, src_en, irq}, 32'h0000_0001);
        rd(ctu_pkg::ADDR_FLAG, 8'h04);
        rd(ctu_pkg::ADDR_LOW, 8'h03);
        wr(ctu_pkg::ADDR_FLAG, 8'h00);
        wr(ctu_pkg::ADDR_IEN, 8'h00);
        wr(ctu_pkg::ADDR_LOW, 8'h02);
        wr(ctu_pkg::ADDR_LOW, 8'h00);
        wt(2);
        rd(ctu_pkg::ADDR_FLAG, 8'h04);
        chk({31'h0, irq}, 32'h0000_0000);
        // Sequencing: edge 2 level present before edge 1 is ignored
        wr(ctu_pkg::ADDR_HIGH, 8'h84);
        lvl_req <= 4'h2;
        wt(3);
        wr(ctu_pkg::ADDR_LOW, 8'hB0);
        wr(ctu_pkg::ADDR_HIGH, 8'h8C);
        wt(3);
        rd(ctu_pkg::ADDR_LOW, 8'hB0);
        lvl_req <= 4'h3;
        wt(4);
        rd(ctu_pkg::ADDR_LOW, 8'hB3);
        // Mid-run reset returns the outputs and the edge control and flag registers to reset values
        presetn <= 1'b0;
        wt(2);
        presetn <= 1'b1;
        wt(2);
        chk({19'h0_0000, src_en, discharge_ctl, delay_mode, unit_on,
             range_sel, trim_val, irq}, 32'h0000_0000);
        rd(ctu_pkg::ADDR_LOW, 8'h00);
        rd(ctu_pkg::ADDR_FLAG, 8'h00);
        end_sim();
    end
endmodule
